// ==== verilog/sdram_wp_pkg.sv ====
/*
 * Shared constants and types for the write/precharge command sequencer of a
 * four-bank single-data-rate synchronous DRAM core.
 * Assumes a single 20 MHz clock and a register bus slave at 32-bit data.
 */
package sdram_wp_pkg;

    // clock and timing, times in ns as printed, counts rounded up, at least one
    localparam int CLK_NS          = 50;
    localparam int T_WR_NS         = 15;
    localparam int T_RP_NS         = 18;
    localparam int T_RAS_NS        = 42;
    localparam int T_RCD_NS        = 18;
    localparam int WR_CYC_I        = (T_WR_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC_I        = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAS_CYC_I       = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] WR_CYC  = 4'((WR_CYC_I < 1) ? 1 : WR_CYC_I);
    localparam logic [3:0] RP_CYC  = 4'((RP_CYC_I < 1) ? 1 : RP_CYC_I);
    localparam logic [3:0] RAS_CYC = 4'((RAS_CYC_I < 1) ? 1 : RAS_CYC_I);

    // array geometry
    localparam int NBANK   = 4;
    localparam int COL_W   = 10;
    localparam int ROW_W   = 13;
    localparam int DQ_W    = 16;
    localparam int AP_BIT  = 10;

    // register offsets (byte addresses)
    localparam logic [3:0] REG_MODE    = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_WRCOUNT = 4'h8;

    // mode register fields and reset value
    localparam int MODE_BL_LSB   = 0;
    localparam int MODE_BT_BIT   = 3;
    localparam int MODE_CL_LSB   = 4;
    localparam int MODE_WBM_BIT  = 9;
    localparam logic [2:0] BL_CONT = 3'h7;
    localparam logic [31:0] MODE_RST = 32'h0000_0023;

    // status register fields
    localparam int STAT_BURST_BIT = 8;
    localparam int STAT_BWR_BIT   = 9;

    // command decode on {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CODE_ACT = 3'h3;
    localparam logic [2:0] CODE_RD  = 3'h5;
    localparam logic [2:0] CODE_WR  = 3'h4;
    localparam logic [2:0] CODE_PRE = 3'h2;
    localparam logic [2:0] CODE_BST = 3'h6;

    typedef enum logic [2:0] {C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_BST} cmd_e;
    typedef enum logic [1:0] {B_IDLE, B_ACTIVE, B_AP_WAIT, B_PRECHARGE} bank_e;

    // command pins sampled on each rising edge
    typedef struct packed {
        logic             cs_n;
        logic             ras_n;
        logic             cas_n;
        logic             we_n;
        logic [1:0]       ba;
        logic [ROW_W-1:0] addr;
        logic [1:0]       dqm;
    } cmd_pins_s;

    // one element access to the cell array
    typedef struct packed {
        logic             en;
        logic [1:0]       be;
        logic [1:0]       bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DQ_W-1:0]  data;
    } array_acc_s;

endpackage

// ==== verilog/sdram_wp_core.sv ====
/*
 * Command sequencer of a four-bank SDRAM core: write bursts, truncation,
 * burst read/single write, precharge of one or all banks, auto precharge with
 * row-active lock-out and concurrent auto precharge, and read output enable.
 * Assumes command pins synchronous to mclk; the cell array sits behind the
 * registered access ports; the mode register is reached over Avalon-MM.
 */
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps

// Overview of operation
// - write burst takes first data on the command edge, then every edge.
// - finished fixed write burst leaves pins undriven and ignores further data.
// - continuous write runs until ended, wrapping from last column to zero.
// - a new write truncates the old one; its coincident data is its own.
// - a read ends the write burst; data from that edge on is dropped.
// - precharge waits write recovery (a precharge command here closes the bank at once, without that wait); auto precharge allows at least one clock.
// - burst terminate drops its own edge data; last write is one earlier.
// - write burst mode bit set makes every write a single column, except at continuous length.
// - precharge with address bit ten low closes one bank, high all.
// - precharged bank is idle; column commands need an activated row.
// - address bit ten on a column command precharges bank at burst end.
// - single write with continuous length keeps continuous, no auto precharge.
// - auto precharge selection applies only to its own command.
// - auto precharge waits until minimum row active time is met.
// - read interrupting auto precharged read starts that precharge at once.
// - write interrupting auto precharged read starts precharge, drops read output.
// - read interrupting auto precharged write precharges after recovery from write.
// - write interrupting auto precharged write precharges after recovery from write.
// - data mask acts on inputs at once, on outputs two clocks later.
module sdram_wp_core
    import sdram_wp_pkg::*;
(
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                arst_n,
    // command and data pins
    input  wire cmd_pins_s           cmd,
    input  wire logic [DQ_W-1:0]     dq_in,
    output logic                     dq_oe,
    // cell array access
    output array_acc_s               arr_wr,
    output array_acc_s               arr_rd,
    // avalon-mm slave
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest
);

    // register bus state
    logic [31:0]            mode_r, mode_nxt;
    logic [31:0]            wrcount_r, wrcount_nxt;
    logic [31:0]            rdata_r, rdata_nxt;
    logic                   ack_r, ack_nxt;
    // burst engine state
    logic                   b_on_r, b_on_nxt;
    logic                   b_wr_r, b_wr_nxt;
    logic                   b_ap_r, b_ap_nxt;
    logic                   b_cont_r, b_cont_nxt;
    logic                   b_bt_r, b_bt_nxt;
    logic [1:0]             b_bank_r, b_bank_nxt;
    logic [COL_W-1:0]       b_start_r, b_start_nxt;
    logic [COL_W-1:0]       b_idx_r, b_idx_nxt;
    logic [3:0]             b_len_r, b_len_nxt;
    array_acc_s             wr_r, wr_nxt;
    array_acc_s             rd_r, rd_nxt;
    logic [2:0]             pipe_r, pipe_nxt;
    logic [1:0]             dqm_d_r;
    logic                   oe_r, oe_nxt;
    // decoded command and per-bank hooks
    cmd_e                   ccmd;
    logic                   col_ok;
    logic                   ends_burst;
    logic [NBANK-1:0]       act_hit, pre_hit, ap_go, ap_wr, bank_open;
    logic [ROW_W-1:0]       bank_row [NBANK];
    logic [1:0]             bank_st [NBANK];
    logic                   req;

    // element column inside the burst: wrap within burst, or whole page
    function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] idx,
                                                 input logic [3:0] len,
                                                 input logic bt, input logic cont);
        logic [COL_W-1:0] mask;
        logic [COL_W-1:0] low;
        mask = {6'h00, len - 4'h1};
        low  = bt ? ((start ^ idx) & mask) : ((start + idx) & mask);
        if (cont) begin
            col_at = start + idx; // natural wrap to column zero
        end else begin
            col_at = (start & ~mask) | low;
        end
    endfunction

    // command decode
    always_comb begin
        ccmd = C_NOP;
        if (!cmd.cs_n) begin
            unique case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
                CODE_ACT: ccmd = C_ACT;
                CODE_RD:  ccmd = C_RD;
                CODE_WR:  ccmd = C_WR;
                CODE_PRE: ccmd = C_PRE;
                CODE_BST: ccmd = C_BST;
                default:  ccmd = C_NOP;
            endcase
        end
    end

    // bank targeting of commands
    always_comb begin
        for (int b = 0; b < NBANK; b++) begin
            act_hit[b] = (ccmd == C_ACT) && (cmd.ba == 2'(b));
            // bit ten high closes all banks, bank select ignored
            pre_hit[b] = (ccmd == C_PRE) && (cmd.addr[AP_BIT] || (cmd.ba == 2'(b)));
        end
        // column commands only reach an activated bank
        col_ok = ((ccmd == C_RD) || (ccmd == C_WR)) && bank_open[cmd.ba];
        ends_burst = col_ok || (ccmd == C_BST) || pre_hit[b_bank_r];
    end

    // burst engine: element issue, truncation and auto precharge events
    always_comb begin
        logic [3:0]       len;
        logic             cont;
        logic             last;
        logic [COL_W-1:0] ccol;
        len = 4'h1;
        cont = 1'b0;
        last = 1'b0;
        ccol = '0;
        b_on_nxt = b_on_r;
        b_wr_nxt = b_wr_r;
        b_ap_nxt = b_ap_r;
        b_cont_nxt = b_cont_r;
        b_bt_nxt = b_bt_r;
        b_bank_nxt = b_bank_r;
        b_start_nxt = b_start_r;
        b_idx_nxt = b_idx_r;
        b_len_nxt = b_len_r;
        wr_nxt = '0;
        rd_nxt = '0;
        ap_go = '0;
        ap_wr = '0;
        if (b_on_r && !ends_burst) begin
            ccol = col_at(b_start_r, b_idx_r, b_len_r, b_bt_r, b_cont_r);
            last = !b_cont_r && (b_idx_r == {6'h00, b_len_r - 4'h1});
            if (b_wr_r) begin
                wr_nxt.en = ~&cmd.dqm; // each edge takes the next element
                wr_nxt.be = ~cmd.dqm; // mask acts with zero latency
                wr_nxt.data = dq_in;
            end else begin
                rd_nxt.en = 1'b1;
                rd_nxt.be = 2'h3;
            end
            wr_nxt.bank = b_bank_r;
            wr_nxt.row = bank_row[b_bank_r];
            wr_nxt.col = ccol;
            rd_nxt.bank = b_bank_r;
            rd_nxt.row = bank_row[b_bank_r];
            rd_nxt.col = ccol;
            b_idx_nxt = b_idx_r + 10'h001;
            if (last) begin
                b_on_nxt = 1'b0; // later data ignored until a new command
                ap_go[b_bank_r] = b_ap_r; // precharge at burst completion
                ap_wr[b_bank_r] = b_wr_r;
            end
        end else if (b_on_r) begin
            // truncation: data on this edge is not part of the old burst
            b_on_nxt = 1'b0;
            // interrupting command starts the old bank's precharge timing
            ap_go[b_bank_r] = b_ap_r;
            ap_wr[b_bank_r] = b_wr_r;
        end
        if (col_ok) begin
            cont = (mode_r[MODE_BL_LSB +: 3] == BL_CONT);
            len = cont ? 4'h8 : (4'h1 << mode_r[MODE_BL_LSB +: 2]);
            if ((ccmd == C_WR) && mode_r[MODE_WBM_BIT] && !cont) begin
                len = 4'h1; // single column write, reads keep length
            end
            b_wr_nxt = (ccmd == C_WR);
            // selection taken per command, none in continuous mode
            b_ap_nxt = cmd.addr[AP_BIT] && !cont;
            b_cont_nxt = cont;
            b_bt_nxt = mode_r[MODE_BT_BIT];
            b_bank_nxt = cmd.ba;
            b_start_nxt = cmd.addr[COL_W-1:0];
            b_len_nxt = len;
            b_idx_nxt = 10'h001;
            b_on_nxt = cont || (len != 4'h1);
            if (ccmd == C_WR) begin
                wr_nxt.en = ~&cmd.dqm; // coincident data belongs to new write
                wr_nxt.be = ~cmd.dqm;
                wr_nxt.data = dq_in;
            end else begin
                rd_nxt.en = 1'b1;
                rd_nxt.be = 2'h3;
            end
            wr_nxt.bank = cmd.ba;
            wr_nxt.row = bank_row[cmd.ba];
            wr_nxt.col = cmd.addr[COL_W-1:0];
            rd_nxt.bank = cmd.ba;
            rd_nxt.row = bank_row[cmd.ba];
            rd_nxt.col = cmd.addr[COL_W-1:0];
            if (!b_on_nxt && b_ap_nxt) begin
                ap_go[cmd.ba] = 1'b1; // single access: lock-out handled per bank
                ap_wr[cmd.ba] = (ccmd == C_WR);
            end
        end
    end

    // read output enable: cas latency pipe, mask two clocks late, cut by write
    always_comb begin
        logic [1:0] cl_idx;
        cl_idx = (mode_r[MODE_CL_LSB +: 2] == 2'h0) ? 2'h0 : (mode_r[MODE_CL_LSB +: 2] - 2'h1);
        pipe_nxt = {pipe_r[1:0], rd_nxt.en};
        if (col_ok && (ccmd == C_WR)) begin
            pipe_nxt = '0; // write registered: drivers released
        end
        oe_nxt = pipe_nxt[cl_idx] && !(&dqm_d_r); // output mask latency two
    end

    // burst engine and output registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            b_on_r <= 1'b0;
            b_wr_r <= 1'b0;
            b_ap_r <= 1'b0;
            b_cont_r <= 1'b0;
            b_bt_r <= 1'b0;
            b_bank_r <= 2'h0;
            b_start_r <= '0;
            b_idx_r <= '0;
            b_len_r <= 4'h1;
            wr_r <= '0;
            rd_r <= '0;
            pipe_r <= 3'h0;
            dqm_d_r <= 2'h0;
            oe_r <= 1'b0;
        end else begin
            b_on_r <= b_on_nxt;
            b_wr_r <= b_wr_nxt;
            b_ap_r <= b_ap_nxt;
            b_cont_r <= b_cont_nxt;
            b_bt_r <= b_bt_nxt;
            b_bank_r <= b_bank_nxt;
            b_start_r <= b_start_nxt;
            b_idx_r <= b_idx_nxt;
            b_len_r <= b_len_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            pipe_r <= pipe_nxt;
            dqm_d_r <= cmd.dqm;
            oe_r <= oe_nxt;
        end
    end

    // per-bank row state, write recovery, lock-out and precharge timing
    for (genvar g = 0; g < NBANK; g++) begin : g_bank
        bank_e            st_r, st_nxt;
        logic [ROW_W-1:0] row_r, row_nxt;
        logic [3:0]       ras_r, ras_nxt;
        logic [3:0]       tmr_r, tmr_nxt;

        always_comb begin
            st_nxt = st_r;
            row_nxt = row_r;
            tmr_nxt = tmr_r;
            ras_nxt = (ras_r == 4'hF) ? ras_r : (ras_r + 4'h1);
            unique case (st_r)
                B_IDLE: begin
                    ras_nxt = 4'h0;
                    if (act_hit[g]) begin
                        st_nxt = B_ACTIVE;
                        row_nxt = cmd.addr;
                    end
                end
                B_ACTIVE: begin
                    if (pre_hit[g]) begin
                        st_nxt = B_PRECHARGE; // reuse waits the period
                        tmr_nxt = RP_CYC;
                    end else if (ap_go[g]) begin
                        st_nxt = B_AP_WAIT;
                        // recovery at least one clock after write data
                        tmr_nxt = ap_wr[g] ? WR_CYC : 4'h0;
                    end
                end
                B_AP_WAIT: begin
                    if (tmr_r != 4'h0) begin
                        tmr_nxt = tmr_r - 4'h1;
                    end else if (ras_r >= RAS_CYC) begin
                        st_nxt = B_PRECHARGE; // row active minimum met
                        tmr_nxt = RP_CYC;
                    end
                end
                B_PRECHARGE: begin
                    tmr_nxt = tmr_r - 4'h1;
                    if (tmr_r <= 4'h1) begin
                        st_nxt = B_IDLE; // idle, must be activated again
                    end
                end
            endcase
        end

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                st_r <= B_IDLE;
                row_r <= '0;
                ras_r <= 4'h0;
                tmr_r <= 4'h0;
            end else begin
                st_r <= st_nxt;
                row_r <= row_nxt;
                ras_r <= ras_nxt;
                tmr_r <= tmr_nxt;
            end
        end

        assign bank_open[g] = (st_r == B_ACTIVE);
        assign bank_row[g]  = row_r;
        assign bank_st[g]   = st_r;
    end

    // register bus: one wait state, write commits at the acknowledging edge
    always_comb begin
        req = avs_read || avs_write;
        ack_nxt = req && !ack_r;
        mode_nxt = mode_r;
        wrcount_nxt = wrcount_r;
        rdata_nxt = rdata_r;
        if (req && !ack_r) begin
            unique case (avs_address)
                REG_MODE:    rdata_nxt = mode_r;
                REG_STATUS:  rdata_nxt = {22'h000000, b_wr_r, b_on_r,
                                          bank_st[3], bank_st[2], bank_st[1], bank_st[0]};
                REG_WRCOUNT: rdata_nxt = wrcount_r;
                default:     rdata_nxt = 32'h0000_0000;
            endcase
        end
        if (avs_write && ack_r) begin
            if (avs_address == REG_MODE) begin
                for (int i = 0; i < 4; i++) begin
                    if (avs_byteenable[i]) begin
                        mode_nxt[8*i +: 8] = avs_writedata[8*i +: 8];
                    end
                end
            end else if (avs_address == REG_WRCOUNT) begin
                wrcount_nxt = 32'h0000_0000;
            end
        end
        // counting after the clear, so a write in the clear cycle survives
        if (wr_nxt.en) begin
            wrcount_nxt = wrcount_nxt + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= MODE_RST;
            wrcount_r <= 32'h0000_0000;
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            wrcount_r <= wrcount_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    // outputs
    assign avs_waitrequest = req && !ack_r;
    assign avs_readdata    = rdata_r;
    assign arr_wr          = wr_r;
    assign arr_rd          = rd_r;
    assign dq_oe           = oe_r;

endmodule

// ==== sim/sdram_wp_properties.sv ====
/* checker: port-level properties of the sdram write/precharge sequencer.
   bound into sdram_wp_core; sees only its ports. */
`timescale 1ns/1ps
module wp_checker
    import sdram_wp_pkg::*;
(
    // clock and reset
    input wire logic            mclk,
    input wire logic            arst_n,
    // pins and array ports
    input wire cmd_pins_s       cmd,
    input wire logic [DQ_W-1:0] dq_in,
    input wire logic            dq_oe,
    input wire array_acc_s      arr_wr,
    input wire array_acc_s      arr_rd
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // command code with chip select
    logic [3:0] op;
    assign op = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    // edges that end a burst write or read nothing
    a_bst_drops: assert property (op == {1'b0, CODE_BST} |=> !arr_wr.en)
        else $error("write after stop");
    a_rd_ends_wr: assert property (op == {1'b0, CODE_RD} |=> !arr_wr.en)
        else $error("write after read");
    a_pre_all: assert property (op == {1'b0, CODE_PRE} && cmd.addr[AP_BIT] |=> !arr_wr.en)
        else $error("write after close all");
    a_wr_ends_rd: assert property (op == {1'b0, CODE_WR} |=> !arr_rd.en)
        else $error("read after write");
    // a written element carries the pins of the edge before
    a_wr_data: assert property (arr_wr.en |-> arr_wr.data == $past(dq_in))
        else $error("data differs");
    a_wr_bytes: assert property (arr_wr.en |-> arr_wr.be == ~$past(cmd.dqm))
        else $error("byte enables differ");
    a_mask_skip: assert property ($past(cmd.dqm) == 2'h3 |-> !arr_wr.en)
        else $error("masked element written");
    a_out_mask: assert property (cmd.dqm == 2'h3 |-> ##2 !dq_oe)
        else $error("output not masked");
    // main scenarios reached
    c_burst: cover property (arr_wr.en [*4]);
    c_stop: cover property (op == {1'b0, CODE_BST});
    c_read_out: cover property (dq_oe);
endmodule
bind sdram_wp_core wp_checker chk (.mclk(mclk), .arst_n(arst_n), .cmd(cmd), .dq_in(dq_in),
    .dq_oe(dq_oe), .arr_wr(arr_wr), .arr_rd(arr_rd));

// ==== sim/ctl_model.sv ====
/* controller model: command pins and write data toward the device.
   assumes one task call at a time from the bench. */
`timescale 1ns/1ps
module ctl_model
    import sdram_wp_pkg::*;
(
    // clock
    input wire logic    mclk,
    // device pins
    output cmd_pins_s   cmd,
    output logic [15:0] dq_in
);
    localparam logic [2:0] NOP = 3'h7;
    // start idle
    initial begin
        cmd = cmd_pins_s'({1'b0, NOP, 15'h0000, 2'h0});
        dq_in = 16'h0000;
    end
    // one command per edge, write data rides with it
    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                         input logic [15:0] d, input logic [1:0] m);
        @(posedge mclk);
        cmd <= cmd_pins_s'({1'b0, c, b, a, m});
        dq_in <= d;
    endtask
    // idle edges, released data keeps toggling
    task automatic nop(input int n);
        repeat (n) begin
            @(posedge mclk);
            cmd <= cmd_pins_s'({1'b0, NOP, 15'h0000, 2'h0});
            dq_in <= ~dq_in;
        end
    endtask
    // activate, then wait activate_to_column_delay
    task automatic open(input logic [1:0] b);
        issue(CODE_ACT, b, 13'h0000, 16'h0000, 2'h0);
        nop(2);
    endtask
    // close after write recovery, never over auto precharge, then precharge_period
    // no mask needed at a 50 ns clock
    task automatic close(input logic [1:0] b, input logic all);
        nop(2);
        issue(CODE_PRE, b, {2'h0, all, 10'h000}, ~dq_in, 2'h0);
        nop(3);
    endtask
endmodule

// ==== sim/tb_top.sv ====
/* bench: write, truncation, mask, mode, auto precharge and precharge cases.
   assumes package and models compile first. */
`timescale 1ns/1ps
module tb_top
    import sdram_wp_pkg::*;
;
    // pins and bus
    logic            mclk = 1'b0;
    logic            arst_n = 1'b0;
    cmd_pins_s       cmd;
    logic [15:0]     dq_in;
    logic            dq_oe;
    array_acc_s      arr_wr;
    array_acc_s      arr_rd;
    logic [3:0]      avs_address = 4'h0;
    logic            avs_read = 1'b0;
    logic            avs_write = 1'b0;
    logic [31:0]     avs_writedata = 32'h0;
    logic [3:0]      avs_byteenable = 4'hF;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    // bench state
    int              n_mismatch = 0;
    int              n_tests = 0;
    int              n_rd = 0;
    array_acc_s      wq[$];
    logic [15:0]     dv[9];
    logic [9:0]      col;
    logic [31:0]     rdv;
    // 20 MHz clock
    always #25 mclk = ~mclk;
    // device and controller
    sdram_wp_core uut (.mclk(mclk), .arst_n(arst_n), .cmd(cmd), .dq_in(dq_in), .dq_oe(dq_oe),
        .arr_wr(arr_wr), .arr_rd(arr_rd), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    ctl_model ctl (.mclk(mclk), .cmd(cmd), .dq_in(dq_in));
    // log array accesses
    always @(posedge mclk) begin
        if (arr_wr.en === 1'b1) wq.push_back(arr_wr);
        if (arr_rd.en === 1'b1) n_rd++;
    end
    // verdict and end of run
    task automatic close_out();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // word compare
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // next logged array write against its expectation
    task automatic chk_wr(input logic [1:0] b, input logic [9:0] c, input logic [15:0] d, input logic [1:0] be);
        array_acc_s g;
        g = '0;
        if (wq.size() > 0) g = wq.pop_front();
        chk_word({1'b0, g.en, g.bank, g.be, g.col, g.data}, {2'b01, b, be, c, d});
    endtask
    // column of element i within a burst block
    function automatic logic [9:0] ecol(input logic [9:0] s, input int i, input int bl);
        return 10'((s & ~(bl - 1)) | ((s + i) & (bl - 1)));
    endfunction
    // avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 16);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            close_out();
        end
    endtask
    // random data and column
    task automatic rnd();
        col = 10'($urandom);
        foreach (dv[i]) dv[i] = 16'($urandom);
    endtask
    // write command plus n-1 data edges
    task automatic wburst(input logic [1:0] b, input logic [9:0] c, input logic ap, input int n);
        ctl.issue(CODE_WR, b, {2'h0, ap, c}, dv[0], 2'h0);
        for (int i = 1; i < n; i++) ctl.issue(3'h7, 2'h0, 13'h0000, dv[i], 2'h0);
    endtask
    // n expected writes, then nothing more
    task automatic expect_wr(input logic [1:0] b, input logic [9:0] c, input int n, input int bl);
        for (int i = 0; i < n; i++) chk_wr(b, ecol(c, i, bl), dv[i], 2'h3);
        chk_word(32'(wq.size()), 32'h0);
        wq.delete();
    endtask
    // main sequence
    initial begin
        void'($urandom(938));
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        bus(1'b0, REG_MODE, 32'h0);
        chk_word(rdv, MODE_RST);
        ctl.open(2'h0);
        ctl.open(2'h1);
        // every fixed length, one edge past the end
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, REG_MODE, 32'h20 | k);
            rnd();
            wburst(2'h0, col, 1'b0, (1 << k) + 1);
            ctl.nop(3);
            expect_wr(2'h0, col, 1 << k, 1 << k);
        end
        // stop after three elements
        rnd();
        wburst(2'h0, col, 1'b0, 3);
        ctl.issue(CODE_BST, 2'h0, 13'h0000, dv[3], 2'h0);
        ctl.nop(3);
        expect_wr(2'h0, col, 3, 8);
        // write cut by a write to bank 1, then by a read
        rnd();
        wburst(2'h0, col, 1'b0, 2);
        ctl.issue(CODE_WR, 2'h1, {3'h0, col}, dv[2], 2'h0);
        ctl.issue(3'h7, 2'h0, 13'h0000, dv[3], 2'h0);
        ctl.issue(CODE_RD, 2'h1, 13'h0000, dv[4], 2'h0);
        ctl.nop(12);
        chk_wr(2'h0, col, dv[0], 2'h3);
        chk_wr(2'h0, ecol(col, 1, 8), dv[1], 2'h3);
        chk_wr(2'h1, col, dv[2], 2'h3);
        chk_wr(2'h1, ecol(col, 1, 8), dv[3], 2'h3);
        expect_wr(2'h1, col, 0, 8);
        // masked elements
        rnd();
        ctl.issue(CODE_WR, 2'h0, {3'h0, col}, dv[0], 2'h3);
        ctl.issue(3'h7, 2'h0, 13'h0000, dv[1], 2'h1);
        ctl.issue(3'h7, 2'h0, 13'h0000, dv[2], 2'h0);
        ctl.issue(CODE_BST, 2'h0, 13'h0000, dv[3], 2'h0);
        ctl.nop(3);
        chk_wr(2'h0, ecol(col, 1, 8), dv[1], 2'h2);
        chk_wr(2'h0, ecol(col, 2, 8), dv[2], 2'h3);
        // single write mode
        bus(1'b1, REG_MODE, 32'h222);
        rnd();
        wburst(2'h0, col, 1'b0, 3);
        ctl.nop(3);
        expect_wr(2'h0, col, 1, 1);
        n_rd = 0;
        ctl.issue(CODE_RD, 2'h0, {3'h0, col}, dv[0], 2'h3);
        ctl.nop(6);
        chk_word(32'(n_rd), 32'h4);
        // continuous page overrides single write and auto precharge
        bus(1'b1, REG_MODE, 32'h227);
        wburst(2'h0, 10'h3FE, 1'b1, 4);
        ctl.issue(CODE_BST, 2'h0, 13'h0000, dv[4], 2'h0);
        ctl.nop(6);
        expect_wr(2'h0, 10'h3FE, 4, 1024);
        bus(1'b0, REG_STATUS, 32'h0);
        chk_word(rdv & 32'h3, 32'h1);
        // auto precharge closes bank 2
        bus(1'b1, REG_MODE, 32'h21);
        ctl.open(2'h2);
        rnd();
        wburst(2'h2, col, 1'b1, 2);
        ctl.nop(8);
        wburst(2'h2, col, 1'b0, 2);
        wburst(2'h1, col, 1'b0, 2);
        ctl.nop(8);
        chk_wr(2'h2, ecol(col, 0, 2), dv[0], 2'h3);
        chk_wr(2'h2, ecol(col, 1, 2), dv[1], 2'h3);
        expect_wr(2'h1, col, 2, 2);
        bus(1'b0, REG_STATUS, 32'h0);
        chk_word(rdv & 32'h3F, 32'h05);
        // close one bank, then all
        ctl.close(2'h1, 1'b0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk_word(rdv & 32'hFF, 32'h01);
        ctl.close(2'h1, 1'b1);
        bus(1'b0, REG_STATUS, 32'h0);
        chk_word(rdv & 32'hFF, 32'h00);
        avs_byteenable <= 4'hE;
        bus(1'b1, REG_MODE, 32'h200);
        bus(1'b0, REG_MODE, 32'h0);
        chk_word(rdv, 32'h221);
        close_out();
    end
endmodule
